/* File: common/seg_pkg.sv */
// shared constants and types for the seven-segment digit driver
package seg_pkg;
   // widths
   localparam int CODE_W      = 4;
   localparam int SEG_W       = 7;
   localparam int CTRL_W      = 8;
   localparam int CAPT_W      = 16;
   localparam int ADDR_W      = 4;
   localparam int DATA_W      = 32;
   // register byte offsets
   localparam logic [3:0] CTRL_OFS    = 4'h0;
   localparam logic [3:0] STATUS_OFS  = 4'h4;
   localparam logic [3:0] SEGMENT_OFS = 4'h8;
   localparam logic [3:0] CAPTURE_OFS = 4'hC;
   // control register fields
   localparam int CTRL_POINT_BIT = 0;
   localparam int CTRL_FORCE_BIT = 1;
   localparam int CTRL_LAMP_BIT  = 2;
   localparam int CTRL_SRC_BIT   = 3;
   localparam int CTRL_CODE_LSB  = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // status register fields
   localparam int STAT_CODE_LSB   = 0;
   localparam int STAT_GATE_BIT   = 4;
   localparam int STAT_RIPPLE_IN_BIT  = 5;
   localparam int STAT_FORCE_BIT      = 6;
   localparam int STAT_ZERO_BIT       = 7;
   localparam int STAT_RIPPLE_OUT_BIT = 8;
   localparam int STAT_POINT_BIT      = 9;
   // segment register fields
   localparam int SEGREG_POINT_BIT    = 7;
   localparam logic [15:0] CAPT_RESET = 16'h0000;
   // our own low drive on the ripple line is seen back after this many edges
   localparam int ECHO_CYCLES = 3;
   localparam logic [3:0] ZERO_CODE  = 4'h0;
   localparam logic [3:0] CODE_RESET = 4'h0;
   // lit masks and the cathode-off pattern, bit order g f e d c b a
   localparam logic [6:0] SEG_ALL_ON = 7'h7F;
   localparam logic [6:0] SEG_N_OFF  = 7'h7F;
   localparam logic [15:0][6:0] SEG_TABLE = {
      7'h00, 7'h38, 7'h73, 7'h76, 7'h79, 7'h40, 7'h67, 7'h7F,
      7'h07, 7'h7D, 7'h6D, 7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F
   };
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } bus_state_t;
endpackage

/* File: rtl/segment_decoder.sv */
// code to active-low segment decoder with registered cathode outputs
`timescale 1ns/10ps
module segment_decoder (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_b,
   // code and blanking controls
   input  wire logic [3:0] code,
   input  wire logic       blank,
   input  wire logic       lamp_test,
   // cathode drive
   output logic [6:0]      segment_n
);
   logic [6:0] lit;
   logic [6:0] segment_n_reg;

   always_comb begin
      lit = seg_pkg::SEG_TABLE[code];
   end

   // one flop per cathode; blanking beats lamp test
   genvar i;
   for (i = 0; i < seg_pkg::SEG_W; i++) begin : g_seg
      always_ff @(posedge clock) begin
         if (!rst_b) begin
            segment_n_reg[i] <= seg_pkg::SEG_N_OFF[i];
         end else if (blank) begin
            segment_n_reg[i] <= 1'b1;
         end else if (lamp_test) begin
            segment_n_reg[i] <= ~seg_pkg::SEG_ALL_ON[i];
         end else begin
            segment_n_reg[i] <= ~lit[i];
         end
      end
   end

   assign segment_n = segment_n_reg;
endmodule // segment_decoder

/* File: rtl/bcd_seven_segment_driver.sv */
// latched four-bit code to seven-segment driver with ripple blanking
// Operation
// - a four-bit digit code drives the matching seven segment outputs
// - gate low: code latches are transparent, segments follow the input code
// - gate rising captures the code; outputs hold until gate returns low
// - codes zero to nine show the decimal numerals
// - ripple-blank input is only ever an input, never driven
// - ripple-blank output line is driven out, and doubles as force-blank input
// - force-blank line held low turns off every segment, overriding everything
// - ripple-blank input blanks only a zero code, and pulls ripple-blank output low
// - display is eight common-anode leds: segments a to g and decimal point
// - a segment lights only while its cathode is driven low
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module bcd_seven_segment_driver #(
   parameter int CODE_WIDTH = 4
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // avalon-mm slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // digit code pins
   input  wire logic [CODE_WIDTH-1:0] digit_code,
   input  wire logic        latch_gate,
   input  wire logic        ripple_blank_in,
   // ripple-blank output / force-blank line
   input  wire logic        ripple_blank_out_level,
   output logic             ripple_blank_out_drive,
   output logic             ripple_blank_out_oe,
   // display cathodes
   output logic [6:0]       segment_n,
   output logic             decimal_point_segment_n
);
   if (CODE_WIDTH != seg_pkg::CODE_W) begin : g_bad_width
      $error("CODE_WIDTH must be 4");
   end

   // pin synchronisers: {ripple line, ripple in, gate, code}
   localparam int PIN_W = CODE_WIDTH + 3;

   logic [PIN_W-1:0] pin_meta_reg;
   logic [PIN_W-1:0] pin_sync_reg;
   logic [PIN_W-1:0] pin_bundle;

   logic [3:0]  code_sync;
   logic        gate_sync;
   logic        ripple_in_sync;
   logic        ripple_line_sync;
   logic        gate_prev_reg;
   logic        gate_rise;

   logic [3:0]  held_code_reg;
   logic [3:0]  shown_code;

   logic [seg_pkg::CTRL_W-1:0] ctrl_reg;
   logic        ctrl_point;
   logic        ctrl_force;
   logic        ctrl_lamp;
   logic        ctrl_src;
   logic [3:0]  ctrl_code;

   logic [seg_pkg::CAPT_W-1:0] capture_count_reg;
   logic [seg_pkg::CAPT_W-1:0] capture_count_next;

   logic        zero_blank;
   logic        ripple_oe_reg;
   logic [seg_pkg::ECHO_CYCLES-2:0] ripple_echo_reg;
   logic        echo_mask;
   logic        force_blank_in;
   logic        blank_all;
   logic        blank_any;
   logic        point_n_reg;

   seg_pkg::bus_state_t bus_state_reg;
   seg_pkg::bus_state_t bus_state_next;
   logic        access_done;
   logic        write_commit;
   logic        read_start;
   logic        lane0_write;
   logic [31:0] readdata_reg;
   logic [31:0] readdata_next;
   logic [31:0] status_word;
   logic [6:0]  segment_n_int;

   // ---------------------------------------------------------------
   // input synchronisation
   // ---------------------------------------------------------------
   assign pin_bundle = {ripple_blank_out_level, ripple_blank_in, latch_gate, digit_code};

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pin_meta_reg <= '1;
         pin_sync_reg <= '1;
      end else begin
         pin_meta_reg <= pin_bundle;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign code_sync     = pin_sync_reg[CODE_WIDTH-1:0];
   assign gate_sync     = pin_sync_reg[CODE_WIDTH];
   assign ripple_in_sync   = pin_sync_reg[CODE_WIDTH+1];
   assign ripple_line_sync = pin_sync_reg[CODE_WIDTH+2];

   // ---------------------------------------------------------------
   // code latch
   // ---------------------------------------------------------------
   // code and gate share one synchroniser stage count, so a rising gate
   // holds the code sampled alongside its last low sample
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         held_code_reg <= seg_pkg::CODE_RESET;
      end else if (!gate_sync) begin
         held_code_reg <= code_sync;
      end else begin
         held_code_reg <= held_code_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         gate_prev_reg <= 1'b1; // same as the synchroniser reset, so release brings no false rise
      end else begin
         gate_prev_reg <= gate_sync;
      end
   end

   assign gate_rise = gate_sync & ~gate_prev_reg;

   // ---------------------------------------------------------------
   // control fields
   // ---------------------------------------------------------------
   assign ctrl_point = ctrl_reg[seg_pkg::CTRL_POINT_BIT];
   assign ctrl_force = ctrl_reg[seg_pkg::CTRL_FORCE_BIT];
   assign ctrl_lamp  = ctrl_reg[seg_pkg::CTRL_LAMP_BIT];
   assign ctrl_src   = ctrl_reg[seg_pkg::CTRL_SRC_BIT];
   assign ctrl_code  = ctrl_reg[seg_pkg::CTRL_CODE_LSB +: 4];

   // software may substitute its own code for the latched one
   assign shown_code = ctrl_src ? ctrl_code : held_code_reg;

   // ---------------------------------------------------------------
   // ripple blanking and force blank
   // ---------------------------------------------------------------
   assign zero_blank = ~ripple_in_sync & (shown_code == seg_pkg::ZERO_CODE);

   // open-drain style: pull low only for zero blanking, otherwise release
   // and let the line's pull-up hold it high
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ripple_oe_reg <= 1'b0;
      end else begin
         ripple_oe_reg <= zero_blank;
      end
   end

   assign ripple_blank_out_drive = 1'b0;
   assign ripple_blank_out_oe    = ripple_oe_reg;

   // our own low drive echoes back through the synchroniser; without this
   // mask a blanked zero would show as a force blank, lasting two cycles after release
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ripple_echo_reg <= '0;
      end else begin
         ripple_echo_reg <= {ripple_echo_reg[seg_pkg::ECHO_CYCLES-3:0], ripple_oe_reg};
      end
   end

   assign echo_mask      = ripple_oe_reg | (|ripple_echo_reg);
   assign force_blank_in = ~ripple_line_sync & ~echo_mask;

   // force blank wins over gate, ripple input, code and lamp test
   assign blank_all = force_blank_in | ctrl_force;
   assign blank_any = blank_all | zero_blank;

   // ---------------------------------------------------------------
   // display outputs
   // ---------------------------------------------------------------
   segment_decoder u_decoder (
      .clock     (clock),
      .rst_b     (rst_b),
      .code      (shown_code),
      .blank     (blank_any),
      .lamp_test (ctrl_lamp),
      .segment_n (segment_n_int)
   );

   assign segment_n = segment_n_int;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         point_n_reg <= 1'b1;
      end else begin
         point_n_reg <= ~((ctrl_point | ctrl_lamp) & ~blank_any);
      end
   end

   assign decimal_point_segment_n = point_n_reg;

   // ---------------------------------------------------------------
   // avalon-mm slave: one wait state on every access
   // ---------------------------------------------------------------
   always_comb begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         seg_pkg::BUS_IDLE: begin
            if (read | write) begin
               bus_state_next = seg_pkg::BUS_ACK;
            end
         end
         seg_pkg::BUS_ACK: begin
            bus_state_next = seg_pkg::BUS_IDLE;
         end
         default: begin
            bus_state_next = seg_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         bus_state_reg <= seg_pkg::BUS_IDLE;
      end else begin
         bus_state_reg <= bus_state_next;
      end
   end

   assign access_done  = (bus_state_reg == seg_pkg::BUS_ACK);
   assign waitrequest  = (read | write) & ~access_done;
   assign write_commit = write & access_done;
   assign read_start   = read & (bus_state_reg == seg_pkg::BUS_IDLE);
   assign lane0_write  = write_commit & byteenable[0];

   // control register, lane 0 only
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ctrl_reg <= seg_pkg::CTRL_RESET;
      end else if (lane0_write && address == seg_pkg::CTRL_OFS) begin
         ctrl_reg <= writedata[seg_pkg::CTRL_W-1:0];
      end
   end

   // capture counter: a gate rise in the clearing cycle still counts
   always_comb begin
      capture_count_next = capture_count_reg;
      if (write_commit && (|byteenable) && address == seg_pkg::CAPTURE_OFS) begin
         capture_count_next = seg_pkg::CAPT_RESET;
      end
      if (gate_rise) begin
         capture_count_next = capture_count_next + 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         capture_count_reg <= seg_pkg::CAPT_RESET;
      end else begin
         capture_count_reg <= capture_count_next;
      end
   end

   // status word
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[seg_pkg::STAT_CODE_LSB +: 4] = shown_code;
      status_word[seg_pkg::STAT_GATE_BIT]      = gate_sync;
      status_word[seg_pkg::STAT_RIPPLE_IN_BIT]  = ripple_in_sync;
      status_word[seg_pkg::STAT_FORCE_BIT]      = force_blank_in;
      status_word[seg_pkg::STAT_ZERO_BIT]       = zero_blank;
      status_word[seg_pkg::STAT_RIPPLE_OUT_BIT] = ripple_oe_reg;
      status_word[seg_pkg::STAT_POINT_BIT]      = ~point_n_reg;
   end

   // read mux; unmapped offsets read as zero
   always_comb begin
      readdata_next = 32'h0000_0000;
      case (address)
         seg_pkg::CTRL_OFS: begin
            readdata_next[seg_pkg::CTRL_W-1:0] = ctrl_reg;
         end
         seg_pkg::STATUS_OFS: begin
            readdata_next = status_word;
         end
         seg_pkg::SEGMENT_OFS: begin
            readdata_next[6:0] = segment_n_int;
            readdata_next[seg_pkg::SEGREG_POINT_BIT] = point_n_reg;
         end
         seg_pkg::CAPTURE_OFS: begin
            readdata_next[seg_pkg::CAPT_W-1:0] = capture_count_reg;
         end
         default: begin
            readdata_next = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         readdata_reg <= 32'h0000_0000;
      end else if (read_start) begin
         readdata_reg <= readdata_next;
      end
   end

   assign readdata = readdata_reg;
endmodule // bcd_seven_segment_driver

/* File: sim/seg_driver_asserts.sv */
// concurrent checks on the digit driver ports
`timescale 1ns/10ps
module seg_driver_asserts (
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_b,
   // bus
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // pins
   input wire logic        ripple_blank_in,
   input wire logic        ripple_blank_out_level,
   input wire logic        ripple_blank_out_drive,
   input wire logic        ripple_blank_out_oe,
   input wire logic [6:0]  segment_n,
   input wire logic        decimal_point_segment_n
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   wait_first_a: assert property ($rose(read || write) |-> waitrequest)
      else $error("bus request not held off in its first cycle");
   wait_state_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus answer later than one wait state");
   idle_ready_a: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest high with no request");
   data_hold_a: assert property (!read |=> $stable(readdata))
      else $error("readdata changed without a read");
   drive_zero_a: assert property (ripple_blank_out_drive == 1'b0)
      else $error("ripple line driven high");
   force_blank_a: assert property ((!ripple_blank_out_level && !ripple_blank_out_oe) [*6]
      |-> segment_n == 7'h7F && decimal_point_segment_n)
      else $error("segments lit while line forced low");
   zero_blank_a: assert property ($rose(ripple_blank_out_oe) |-> ##[0:1] segment_n == 7'h7F)
      else $error("ripple output low without blanking");
   ripple_release_a: assert property (ripple_blank_in [*6] |-> !ripple_blank_out_oe)
      else $error("ripple output pulled with blank input high");
   reset_dark_a: assert property (disable iff (1'b0) !rst_b |=> segment_n == 7'h7F && !ripple_blank_out_oe)
      else $error("display not dark in reset");
endmodule // seg_driver_asserts

bind bcd_seven_segment_driver seg_driver_asserts u_seg_driver_asserts (
   .clock(clock), .rst_b(rst_b), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .ripple_blank_in(ripple_blank_in),
   .ripple_blank_out_level(ripple_blank_out_level), .ripple_blank_out_drive(ripple_blank_out_drive),
   .ripple_blank_out_oe(ripple_blank_out_oe), .segment_n(segment_n),
   .decimal_point_segment_n(decimal_point_segment_n)
);

/* File: sim/seg_far_side.sv */
// ripple line with pull-up and outside force, plus the led digit
`timescale 1ns/10ps
module seg_far_side (
   // ripple line
   input  wire logic       oe,
   input  wire logic       drive,
   input  wire logic       ext_low,
   output logic            level,
   // cathodes in, lit leds out as point then g..a
   input  wire logic [6:0] seg_n,
   input  wire logic       point_n,
   output logic [7:0]      lit
);
   // open drain: any puller wins, pull-up otherwise
   assign level = ((oe && !drive) || ext_low) ? 1'b0 : 1'b1;
   // common anode: a led glows only on a low cathode
   assign lit = ~{point_n, seg_n};
endmodule // seg_far_side

/* File: sim/bcd_seven_segment_driver_tb_top.sv */
// register and pin tests for the digit driver
`timescale 1ns/10ps
module bcd_seven_segment_driver_tb_top;
   logic        clock, rst_b, read, write, latch_gate, ripple_blank_in, ext_low;
   logic [3:0]  address, byteenable, digit_code;
   logic [31:0] writedata, readdata, q;
   logic        waitrequest, ripple_level, ripple_drive, ripple_oe, point_n;
   logic [6:0]  segment_n;
   logic [7:0]  lit;
   int          n_errors, checked, i;
   logic [6:0]  glyph [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
                               7'h7F, 7'h67, 7'h40, 7'h79, 7'h76, 7'h73, 7'h38, 7'h00};

   bcd_seven_segment_driver u_bcd_seven_segment_driver (
      .clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .digit_code(digit_code), .latch_gate(latch_gate), .ripple_blank_in(ripple_blank_in),
      .ripple_blank_out_level(ripple_level), .ripple_blank_out_drive(ripple_drive),
      .ripple_blank_out_oe(ripple_oe), .segment_n(segment_n), .decimal_point_segment_n(point_n));
   seg_far_side u_seg_far_side (.oe(ripple_oe), .drive(ripple_drive), .ext_low(ext_low), .level(ripple_level),
      .seg_n(segment_n), .point_n(point_n), .lit(lit));

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask

   // one access; waitrequest and readdata are taken at the rising edge, before
   // that edge's updates, and the request drops only after that edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      @(posedge clock);
      while (waitrequest !== 1'b0 && n < 50) begin
         n++;
         @(posedge clock);
      end
      if (n >= 50) n_errors++;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   // pins settle through the synchronisers before the display is judged
   task automatic pins(input logic [3:0] c, input logic g, input logic r, input logic f);
      @(posedge clock);
      digit_code <= c;
      latch_gate <= g;
      ripple_blank_in <= r;
      ext_low <= f;
      repeat (8) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      end_of_test();
   end

   initial begin
      {rst_b, read, write, latch_gate, ext_low} = 5'h00;
      {address, digit_code, writedata} = 40'h00;
      byteenable = 4'hF;
      ripple_blank_in = 1'b1;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      bus(1'b0, seg_pkg::CTRL_OFS, 32'h0);
      chk("ctrl reset", q, 32'h0);
      bus(1'b0, seg_pkg::CAPTURE_OFS, 32'h0);
      chk("capture reset", q, 32'h0);
      bus(1'b1, 4'h1, 32'hFF);
      bus(1'b0, 4'h1, 32'h0);
      chk("unmapped", q, 32'h0);
      for (i = 0; i < 16; i++) begin
         pins(4'(i), 1'b0, 1'b1, 1'b0);
         chk("glyph", 32'(lit), 32'(glyph[i]));
      end
      pins(4'h3, 1'b0, 1'b1, 1'b0);
      pins(4'h3, 1'b1, 1'b1, 1'b0);
      pins(4'h8, 1'b1, 1'b1, 1'b0);
      chk("held code", 32'(lit), 32'(glyph[3]));
      bus(1'b0, seg_pkg::CAPTURE_OFS, 32'h0);
      chk("gate rises", q, 32'h1);
      pins(4'h8, 1'b0, 1'b1, 1'b0);
      chk("follow code", 32'(lit), 32'(glyph[8]));
      pins(4'h0, 1'b0, 1'b0, 1'b0);
      chk("zero blank", 32'(lit), 32'h0);
      chk("ripple low", 32'(ripple_level), 32'h0);
      pins(4'h5, 1'b0, 1'b0, 1'b0);
      chk("nonzero shown", 32'(lit), 32'(glyph[5]));
      chk("ripple idle", 32'(ripple_oe), 32'h0);
      pins(4'h0, 1'b0, 1'b1, 1'b0);
      chk("zero shown", 32'(lit), 32'(glyph[0]));
      chk("ripple high", 32'(ripple_level), 32'h1);
      bus(1'b1, seg_pkg::CTRL_OFS, 32'h1);
      pins(4'h8, 1'b0, 1'b1, 1'b0);
      chk("point lit", 32'(lit), 32'({1'b1, glyph[8]}));
      pins(4'h8, 1'b1, 1'b1, 1'b1);
      chk("force blank", 32'(lit), 32'h0);
      bus(1'b0, seg_pkg::STATUS_OFS, 32'h0);
      chk("status forced", q, 32'h78);
      bus(1'b0, seg_pkg::SEGMENT_OFS, 32'h0);
      chk("segment reg", q, 32'hFF);
      bus(1'b1, seg_pkg::CTRL_OFS, 32'h4);
      pins(4'h8, 1'b1, 1'b1, 1'b0);
      chk("lamp test", 32'(lit), 32'hFF);
      bus(1'b1, seg_pkg::CTRL_OFS, 32'hFFFF_FF58);
      bus(1'b0, seg_pkg::CTRL_OFS, 32'h0);
      chk("ctrl width", q, 32'h58);
      pins(4'h8, 1'b1, 1'b1, 1'b0);
      chk("soft code", 32'(lit), 32'(glyph[5]));
      bus(1'b1, seg_pkg::CTRL_OFS, 32'hA);
      pins(4'h8, 1'b1, 1'b1, 1'b0);
      chk("soft force", 32'(lit), 32'h0);
      bus(1'b0, seg_pkg::CAPTURE_OFS, 32'h0);
      chk("capture count", q, 32'h2);
      bus(1'b1, seg_pkg::CAPTURE_OFS, 32'h0);
      bus(1'b0, seg_pkg::CAPTURE_OFS, 32'h0);
      chk("capture clear", q, 32'h0);
      end_of_test();
   end
endmodule // bcd_seven_segment_driver_tb_top
